// ===== src/gip_pkg.sv
// Shared constants and types for the grouped interrupt prioritizer.
// Assumes a single clock; register indices map to byte addresses times four.
package gip_pkg;

    // Structure
    localparam int GIP_GROUPS = 64;
    localparam int GIP_LINES = 32;
    localparam int GIP_LEVELS = 4;
    localparam int GIP_GRP_W = 6;
    localparam int GIP_OFS_W = 14;
    localparam int GIP_LVL_W = 2;
    localparam int GIP_ADDR_W = 12;
    localparam int GIP_NLINES = GIP_GROUPS * GIP_LINES;

    // Register indices; byte address is four times the index
    localparam logic [9:0] GIP_CFG_BASE_IDX = 10'h000;
    localparam logic [9:0] GIP_REQ_BASE_IDX = 10'h0FF;
    localparam logic [9:0] GIP_CAUSE_BASE_IDX = 10'h200;
    localparam logic [9:0] GIP_BANK_SPAN = 10'h100;
    localparam logic [9:0] GIP_CAUSE_SPAN = 10'h010;

    // Field positions
    localparam int GIP_LVL_HI = 31;
    localparam int GIP_LVL_LO = 30;
    localparam int GIP_OFS_HI = 13;
    localparam int GIP_CAUSE_HI = 5;

    // Reset value of a priority configuration register
    localparam logic [31:0] GIP_CFG_RESET = 32'h0000_0000;

    // Fixed positions of known request sources (group, line)
    localparam int GIP_G_CPU_CMP = 0;
    localparam int GIP_G_DEBUG = 1;
    localparam int GIP_G_FLASH = 2;
    localparam int GIP_G_PROT = 3;
    localparam int GIP_G_DMA = 4;
    localparam int GIP_DMA_CH = 12;
    localparam int GIP_DMA_PER_G = 4;
    localparam int GIP_G_PWR = 7;
    localparam int GIP_G_SYSCTL = 8;
    localparam int GIP_G_ALARM = 9;

    typedef struct packed {
        logic [GIP_LVL_W-1:0] level;
        logic [GIP_OFS_W-1:0] offset;
    } gip_cfg_t;

    typedef struct packed {
        logic valid;
        logic [GIP_LVL_W-1:0] level;
        logic [GIP_OFS_W-1:0] offset;
    } gip_cpu_req_t;

endpackage

// ===== src/gip_level_pick.sv
// Lowest-numbered-group finder for one priority level.
// Assumes candidates are already qualified by level.
module gip_level_pick import gip_pkg::*; #(
    parameter int N = GIP_GROUPS
) (
    // Candidates
    input wire logic [N-1:0] cand,
    // Result
    output logic any,
    output logic [$clog2(N)-1:0] idx
);

    assign any = |cand;

    // Scan downward so the lowest set bit is the last one kept
    always_comb begin
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (cand[i]) begin
                idx = i[$clog2(N)-1:0];
            end
        end
    end

endmodule // gip_level_pick

// ===== src/gip_apb_if.sv
// APB slave handshake: one wait state, more while bus_clk_en is low, then a one-cycle ready.
// Assumes the master holds its request until ready is seen.
module gip_apb_if (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_clk_en,
    // APB control
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // Strobes toward the register file
    output logic rd_load,
    output logic wr_commit,
    output logic pready_q
);

    logic pready_d;

    // Access is taken only on an enabled bus-interface tick
    assign rd_load = psel && penable && !pready_q && bus_clk_en;
    assign pready_d = rd_load;
    assign wr_commit = psel && penable && pready_q && pwrite;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

    a_apb_ready_next: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready_q && bus_clk_en) |=> pready_q) else $error("ready missing");
    a_apb_ready_one: assert property (@(posedge clk) disable iff (rst)
        pready_q |=> !pready_q) else $error("ready held");

endmodule // gip_apb_if

// ===== src/gip_top.sv
// Grouped interrupt prioritizer: request sampling, level pick, CPU request, APB registers.
// Assumes all inputs synchronous to clk; bus_clk_en paces the bus interface.
// How it works
// RULE1: Level field in top two bits, 11 highest.
// RULE2: Fourteen-bit handler offset forwarded to processor.
// RULE3: Software writes offset bit zero as zero.
// RULE4: Request bit reads one while line pending.
// RULE5: Sixty-four request registers, bit n line 32x+n.
// RULE6: Requests sampled continuously, read-only.
// RULE7: Per-level cause register holds winning group.
// RULE8: Cause value meaningful only while level pending.
// RULE9: Whole group shares one level and offset.
// RULE10: Groups 0-3 carry CPU, debug, flash, protection.
// RULE11: DMA channel k on group 4+k/4, line k%4.
// RULE12: Groups 7-9 carry power, system control, alarm.
// RULE13: Register interface paced by its own bus clock.
// RULE14: Lowest-numbered group wins within a level.
// RULE15: Global or level mask blocks the request.
// RULE16: Group pending is OR of its lines.
// RULE17: CPU request three cycles after line asserts.
// RULE18: Read-only writes ignored, unused bits read zero.
module gip_top import gip_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GIP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    // Named request sources
    input wire logic cpu_compare_request,
    input wire logic debug_emu_written,
    input wire logic debug_cpu_read_done,
    input wire logic flash_controller_request,
    input wire logic access_protection_request,
    input wire logic [GIP_DMA_CH-1:0] dma_channel_request,
    input wire logic power_manager_request,
    input wire logic system_control_request,
    input wire logic async_timer_alarm,
    // Remaining request lines, group-major
    input wire logic [GIP_NLINES-1:0] other_lines,
    // Processor status masks
    input wire logic global_mask,
    input wire logic [GIP_LEVELS-1:0] level_mask,
    // Request toward the processor
    output gip_cpu_req_t cpu_req_q
);

    function automatic int unsigned line_pos(input int g, input int l);
        return g * GIP_LINES + l;
    endfunction

    // Line assembly
    logic [GIP_NLINES-1:0] line_vec;

    always_comb begin
        line_vec = other_lines;
        line_vec[line_pos(GIP_G_CPU_CMP, 0)] = cpu_compare_request; // RULE10
        line_vec[line_pos(GIP_G_DEBUG, 0)] = debug_emu_written; // RULE10
        line_vec[line_pos(GIP_G_DEBUG, 1)] = debug_cpu_read_done; // RULE10
        line_vec[line_pos(GIP_G_FLASH, 0)] = flash_controller_request; // RULE10
        line_vec[line_pos(GIP_G_PROT, 0)] = access_protection_request; // RULE10
        for (int k = 0; k < GIP_DMA_CH; k++) begin
            line_vec[line_pos(GIP_G_DMA + k / GIP_DMA_PER_G, k % GIP_DMA_PER_G)] = dma_channel_request[k]; // RULE11
        end
        line_vec[line_pos(GIP_G_PWR, 0)] = power_manager_request; // RULE12
        line_vec[line_pos(GIP_G_SYSCTL, 0)] = system_control_request; // RULE12
        line_vec[line_pos(GIP_G_ALARM, 0)] = async_timer_alarm; // RULE12
    end

    // Stage 1: request sampling
    logic [GIP_NLINES-1:0] req_q;
    logic [GIP_NLINES-1:0] req_d;
    assign req_d = line_vec;

    always_ff @(posedge clk) begin
        if (rst) begin
            req_q <= '0;
        end else begin
            req_q <= req_d; // RULE4 RULE5 RULE6
        end
    end

    // Configuration storage
    gip_cfg_t cfg_q [GIP_GROUPS];

    // Group pending and per-level candidates
    logic [GIP_GROUPS-1:0] group_pending;
    logic [GIP_GROUPS-1:0] cand [GIP_LEVELS];
    logic [GIP_LEVELS-1:0] lvl_any;
    logic [GIP_GRP_W-1:0] lvl_idx [GIP_LEVELS];

    for (genvar g = 0; g < GIP_GROUPS; g++) begin : g_grp
        assign group_pending[g] = |req_q[g*GIP_LINES +: GIP_LINES]; // RULE16
        for (genvar l = 0; l < GIP_LEVELS; l++) begin : g_lvl
            assign cand[l][g] = group_pending[g] && (cfg_q[g].level == GIP_LVL_W'(l)); // RULE9
        end
    end

    for (genvar l = 0; l < GIP_LEVELS; l++) begin : g_pick
        gip_level_pick #(.N(GIP_GROUPS)) u_pick (
            .cand(cand[l]),
            .any(lvl_any[l]),
            .idx(lvl_idx[l])
        ); // RULE14
    end

    // Stage 2: per-level pending and winner
    logic [GIP_LEVELS-1:0] lvl_pend_q;
    logic [GIP_GRP_W-1:0] lvl_win_q [GIP_LEVELS];

    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_pend_q <= '0;
            for (int l = 0; l < GIP_LEVELS; l++) begin
                lvl_win_q[l] <= '0;
            end
        end else begin
            lvl_pend_q <= lvl_any;
            for (int l = 0; l < GIP_LEVELS; l++) begin
                lvl_win_q[l] <= lvl_idx[l]; // RULE7 RULE8
            end
        end
    end

    // Stage 3: masking and highest-level selection
    logic [GIP_LEVELS-1:0] lvl_valid;
    logic sel_any;
    logic [GIP_LVL_W-1:0] sel_lvl;
    gip_cfg_t sel_cfg;
    gip_cpu_req_t cpu_req_d;

    assign lvl_valid = lvl_pend_q & ~level_mask & {GIP_LEVELS{!global_mask}}; // RULE15
    assign sel_any = |lvl_valid;

    always_comb begin
        sel_lvl = '0;
        for (int l = 0; l < GIP_LEVELS; l++) begin
            if (lvl_valid[l]) begin
                sel_lvl = l[GIP_LVL_W-1:0]; // RULE1
            end
        end
    end

    assign sel_cfg = cfg_q[lvl_win_q[sel_lvl]];
    assign cpu_req_d = '{valid: sel_any, level: sel_lvl, offset: sel_cfg.offset}; // RULE2

    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_req_q <= '0;
        end else begin
            cpu_req_q <= cpu_req_d; // RULE17
        end
    end

    // Bus handshake
    logic rd_load;
    logic wr_commit;

    gip_apb_if u_apb (
        .clk(clk),
        .rst(rst),
        .bus_clk_en(bus_clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .rd_load(rd_load),
        .wr_commit(wr_commit),
        .pready_q(pready_q)
    ); // RULE13

    // Address decode
    logic [9:0] word;
    logic [9:0] req_off;
    logic [9:0] cause_off;
    logic hit_cfg;
    logic hit_req;
    logic hit_cause;
    logic [GIP_GRP_W-1:0] cfg_idx;
    logic [GIP_GRP_W-1:0] req_idx;
    logic [GIP_LVL_W-1:0] cause_lvl;

    assign word = paddr[GIP_ADDR_W-1:2];
    assign req_off = word - GIP_REQ_BASE_IDX;
    assign cause_off = word - GIP_CAUSE_BASE_IDX;
    assign hit_cfg = (word < GIP_CFG_BASE_IDX + GIP_BANK_SPAN) && (word[1:0] == 2'b00);
    assign hit_req = (word >= GIP_REQ_BASE_IDX) && (req_off < GIP_BANK_SPAN) && (req_off[1:0] == 2'b00);
    assign hit_cause = (word >= GIP_CAUSE_BASE_IDX) && (cause_off < GIP_CAUSE_SPAN) && (cause_off[1:0] == 2'b00);
    assign cfg_idx = word[7:2];
    assign req_idx = req_off[7:2];
    assign cause_lvl = 2'h3 - cause_off[3:2];

    // Read data selection
    logic [31:0] cfg_word;
    logic [31:0] rd_word;
    logic [31:0] prdata_d;
    logic pslverr_d;

    assign cfg_word = {cfg_q[cfg_idx].level, 16'h0000, cfg_q[cfg_idx].offset};
    assign rd_word = hit_cfg ? cfg_word :
                     hit_req ? req_q[req_idx*GIP_LINES +: GIP_LINES] : // RULE5
                     hit_cause ? {26'h0000000, lvl_win_q[cause_lvl]} : // RULE18
                     32'h0000_0000;
    assign prdata_d = rd_load ? rd_word : prdata_q;
    assign pslverr_d = rd_load ? !(hit_cfg || hit_req || hit_cause) : 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Configuration writes; other regions ignore writes
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int g = 0; g < GIP_GROUPS; g++) begin
                cfg_q[g] <= '{GIP_CFG_RESET[GIP_LVL_HI:GIP_LVL_LO], GIP_CFG_RESET[GIP_OFS_HI:0]};
            end
        end else if (wr_commit && hit_cfg) begin
            cfg_q[cfg_idx] <= '{pwdata[GIP_LVL_HI:GIP_LVL_LO], pwdata[GIP_OFS_HI:0]}; // RULE1 RULE2 RULE3 RULE18
        end
    end

    // Checks
    logic mask_open;
    assign mask_open = !global_mask && (level_mask == '0);

    a_irq_three_cycles: assert property (@(posedge clk) disable iff (rst) // RULE17
        ((|line_vec) && mask_open) ##1 mask_open ##1 mask_open |=> cpu_req_q.valid)
        else $error("request not raised after three cycles");

    a_irq_not_early: assert property (@(posedge clk) disable iff (rst) // RULE17
        (!(|line_vec))[*3] |=> !cpu_req_q.valid)
        else $error("request raised without a line");

    a_global_mask_block: assert property (@(posedge clk) disable iff (rst) // RULE15
        global_mask |=> !cpu_req_q.valid)
        else $error("global mask ignored");

    a_level_is_valid: assert property (@(posedge clk) disable iff (rst) // RULE1
        cpu_req_q.valid |-> (($past(lvl_valid) >> cpu_req_q.level) == 4'h1))
        else $error("level not pending or masked");

    a_offset_forward: assert property (@(posedge clk) disable iff (rst) // RULE2
        cpu_req_q.valid |-> cpu_req_q.offset == $past(sel_cfg.offset))
        else $error("offset not forwarded");

    a_cause_lowest: assert property (@(posedge clk) disable iff (rst) // RULE14
        lvl_pend_q[3] |-> ((($past(cand[3]) >> lvl_win_q[3]) & 64'h1) == 64'h1)
            && (($past(cand[3]) & ((64'h1 << lvl_win_q[3]) - 64'h1)) == 64'h0))
        else $error("cause not the lowest group");

    a_group_or_lines: assert property (@(posedge clk) disable iff (rst) // RULE16
        group_pending[GIP_G_DMA] == $past(|line_vec[line_pos(GIP_G_DMA, 0) +: GIP_LINES]))
        else $error("group pending not OR of lines");

    a_dma_map: assert property (@(posedge clk) disable iff (rst) // RULE11
        req_q[line_pos(GIP_G_DMA + 2, 1)] == $past(dma_channel_request[9]))
        else $error("dma channel misplaced");

    a_cause_upper_zero: assert property (@(posedge clk) disable iff (rst) // RULE18
        (pready_q && !pslverr_q && $past(hit_cause)) |-> prdata_q[31:GIP_CAUSE_HI+1] == 26'h0000000)
        else $error("cause upper bits not zero");

    a_err_with_ready: assert property (@(posedge clk) disable iff (rst) // RULE18
        pslverr_q |-> pready_q)
        else $error("error without ready");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // RULE18
        (pready_q && pslverr_q) |-> prdata_q == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_cfg_gap_zero: assert property (@(posedge clk) disable iff (rst) // RULE18
        (pready_q && !pslverr_q && $past(hit_cfg)) |-> prdata_q[29:14] == 16'h0000)
        else $error("config unused bits not zero");

    a_cfg_write_lands: assert property (@(posedge clk) disable iff (rst) // RULE1 RULE2
        (wr_commit && hit_cfg) |=> cfg_q[$past(cfg_idx)].offset == $past(pwdata[GIP_OFS_HI:0])
            && cfg_q[$past(cfg_idx)].level == $past(pwdata[GIP_LVL_HI:GIP_LVL_LO]))
        else $error("config write lost");

    a_req_sampled: assert property (@(posedge clk) disable iff (rst) // RULE6
        !$past(rst) |-> req_q == $past(line_vec))
        else $error("request lines not sampled");

    a_all_levels_block: assert property (@(posedge clk) disable iff (rst) // RULE15
        (&level_mask) |=> !cpu_req_q.valid)
        else $error("level masks ignored");

    c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(cpu_req_q.valid));
    c_level3_win: cover property (@(posedge clk) disable iff (rst) cpu_req_q.valid && cpu_req_q.level == 2'h3);
    c_cfg_write: cover property (@(posedge clk) disable iff (rst) wr_commit && hit_cfg);
    c_unmapped_err: cover property (@(posedge clk) disable iff (rst) pready_q && pslverr_q);
    c_level_contest: cover property (@(posedge clk) disable iff (rst) $countones(cand[2]) > 1);

endmodule // gip_top

// ===== sim/gip_cpu_model.sv
// Processor-side model: takes the interrupt request and drives the status masks.
// Assumes the bench commands the masks; accepting a request masks its level and below.
module gip_cpu_model import gip_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from the controller
    input wire gip_cpu_req_t req,
    // Bench commands
    input wire logic gm_cmd,
    input wire logic [GIP_LEVELS-1:0] lm_cmd,
    input wire logic accept_en,
    // Status masks
    output logic global_mask,
    output logic [GIP_LEVELS-1:0] level_mask
);
    logic [GIP_LEVELS-1:0] held_q;
    wire logic [GIP_LEVELS-1:0] take_mask = (4'h2 << req.level) - 4'h1;

    always_ff @(posedge clk) begin
        if (rst) begin
            held_q <= '0;
            global_mask <= 1'b0;
            level_mask <= '0;
        end else begin
            held_q <= !accept_en ? '0 : (req.valid ? held_q | take_mask : held_q);
            global_mask <= gm_cmd;
            level_mask <= lm_cmd | held_q;
        end
    end
endmodule // gip_cpu_model

// ===== sim/tb.sv
// Bench for the grouped interrupt prioritizer: APB registers, request map, priority path.
// Assumes gip_top and gip_cpu_model; bus_clk_en is paced here.
module tb import gip_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, bus_clk_en, psel, penable, pwrite, pready_q, pslverr_q, re;
    logic gm_cmd, accept_en, jitter, global_mask;
    logic [GIP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata_q, rv;
    logic [7:0] src;
    logic [GIP_DMA_CH-1:0] dma;
    logic [GIP_NLINES-1:0] lines;
    logic [GIP_LEVELS-1:0] level_mask, lm_cmd;
    gip_cpu_req_t cpu_req_q;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int sg[8] = '{0, 1, 1, 2, 3, 7, 8, 9};
    int sl[8] = '{0, 0, 1, 0, 0, 0, 0, 0};

    gip_top dut (.clk(clk), .rst(rst), .bus_clk_en(bus_clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .cpu_compare_request(src[0]), .debug_emu_written(src[1]),
        .debug_cpu_read_done(src[2]), .flash_controller_request(src[3]), .access_protection_request(src[4]),
        .dma_channel_request(dma), .power_manager_request(src[5]), .system_control_request(src[6]),
        .async_timer_alarm(src[7]), .other_lines(lines), .global_mask(global_mask),
        .level_mask(level_mask), .cpu_req_q(cpu_req_q));

    gip_cpu_model cpu (.clk(clk), .rst(rst), .req(cpu_req_q), .gm_cmd(gm_cmd), .lm_cmd(lm_cmd),
        .accept_en(accept_en), .global_mask(global_mask), .level_mask(level_mask));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        bus_clk_en <= jitter ? 1'($urandom) : 1'b1;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    function automatic logic [11:0] cfg_a(int g);
        return 12'(16 * g);
    endfunction

    function automatic logic [11:0] req_a(int x);
        return 12'(12'h3FC + 16 * x);
    endfunction

    function automatic logic [11:0] cause_a(int l);
        return 12'(12'h800 + 16 * (3 - l));
    endfunction

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(logic w, logic [11:0] a, logic [31:0] d = 32'h0);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready_q !== 1'b1);
        rv = prdata_q;
        re = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ticks(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        int g, x, n, a, b, c;
        logic [31:0] d;
        rst = 1'b1;
        bus_clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        src = '0;
        dma = '0;
        lines = '0;
        gm_cmd = 1'b0;
        lm_cmd = '0;
        accept_en = 1'b0;
        jitter = 1'b0;
        void'($urandom(32'h86D6));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 check("cpu_req_reset", 32'(cpu_req_q), 32'h0);
        acc(0, cfg_a(63));
        check("cfg_reset", rv, 32'h0);
        for (int i = 0; i < 8; i++) begin
            g = $urandom % 64;
            d = (i == 0) ? 32'hFFFF_FFFE : $urandom & 32'hFFFF_FFFE;
            acc(1, cfg_a(g), d);
            acc(0, cfg_a(g));
            check("cfg", rv, d & 32'hC000_3FFF);
        end
        jitter <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            x = 10 + $urandom % 54;
            n = $urandom % 32;
            @(posedge clk);
            lines[32 * x + n] <= 1'b1;
            acc(0, req_a(x));
            check("reqreg", rv, 32'h1 << n);
            acc(1, req_a(x), 32'hFFFF_FFFF);
            check("ro_err", 32'(re), 32'h0);
            @(posedge clk);
            lines[32 * x + n] <= 1'b0;
            acc(0, req_a(x));
            check("reqreg_clr", rv, 32'h0);
        end
        jitter <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            g = k < 8 ? sg[k] : 4 + (k - 8) / 4;
            n = k < 8 ? sl[k] : (k - 8) % 4;
            @(posedge clk);
            if (k < 8) src[k] <= 1'b1;
            else dma[k - 8] <= 1'b1;
            acc(0, req_a(g));
            check("srcmap", rv, 32'h1 << n);
            @(posedge clk);
            src <= '0;
            dma <= '0;
        end
        for (int l = 0; l < 4; l++) begin
            x = 10 + $urandom % 54;
            n = $urandom % 32;
            d = {l[1:0], 16'h0, 14'($urandom) & 14'h3FFE};
            acc(1, cfg_a(x), d);
            @(posedge clk);
            lines[32 * x + n] <= 1'b1;
            ticks(2);
            check("early", 32'(cpu_req_q.valid), 32'h0);
            ticks(1);
            check("req", 32'(cpu_req_q), {15'h0, 1'b1, d[31:30], d[13:0]});
            @(posedge clk);
            lines[32 * x + n] <= 1'b0;
            ticks(3);
            check("req_drop", 32'(cpu_req_q.valid), 32'h0);
        end
        a = 10 + $urandom % 20;
        b = a + 1 + $urandom % 10;
        c = b + 1 + $urandom % 10;
        acc(1, cfg_a(a), 32'h8000_0124);
        acc(1, cfg_a(b), 32'h8000_0AA8);
        acc(1, cfg_a(c), 32'h4000_0050);
        @(posedge clk);
        lines[32 * b + 3] <= 1'b1;
        lines[32 * a + 31] <= 1'b1;
        lines[32 * c] <= 1'b1;
        ticks(4);
        check("winner", 32'(cpu_req_q), 32'h0001_8124);
        acc(0, cause_a(2));
        check("cause2", rv, 32'(a));
        acc(0, cause_a(1));
        check("cause1", rv, 32'(c));
        @(posedge clk);
        lm_cmd <= 4'h4;
        ticks(4);
        check("lvl_mask", 32'(cpu_req_q), 32'h0001_4050);
        @(posedge clk);
        gm_cmd <= 1'b1;
        ticks(3);
        check("glb_mask", 32'(cpu_req_q.valid), 32'h0);
        @(posedge clk);
        gm_cmd <= 1'b0;
        lm_cmd <= 4'h0;
        accept_en <= 1'b1;
        ticks(8);
        check("accepted", 32'(cpu_req_q.valid), 32'h0);
        @(posedge clk);
        lines <= '0;
        accept_en <= 1'b0;
        acc(0, 12'hFF0);
        check("unmapped_err", 32'(re), 32'h1);
        check("unmapped_data", rv, 32'h0);
        stop_test();
    end
endmodule // tb
